// ===== psm_pkg.sv
/*
  constants and types shared by the pin state mode controller:
  register offsets, field positions, reset values, timing counts.
  assumes a 100 MHz system clock.
*/
`default_nettype none
package psm_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int BUS_W = 16;

  // register byte addresses
  localparam logic [ADDR_W-1:0] OFS_CTRL = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 32'h0000_0004;

  // control register fields
  localparam int CTRL_BUS_EN = 0;
  localparam int CTRL_SEP_BUS = 1;
  localparam int CTRL_DBG_SEL = 2;
  localparam int CTRL_MODE_LO = 4;
  localparam int CTRL_MODE_HI = 5;

  // status register fields
  localparam int STAT_STATE_LO = 0;
  localparam int STAT_STATE_HI = 2;
  localparam int STAT_HOLD = 4;
  localparam int STAT_WINDOW = 5;
  localparam int STAT_DMA = 6;
  localparam int STAT_EXT_RST = 7;

  localparam logic CTRL_BUS_EN_RST = 1'b0;
  localparam logic CTRL_SEP_BUS_RST = 1'b0;
  localparam logic CTRL_DBG_SEL_RST = 1'b0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // power-on pin state window
  localparam int CLK_PERIOD_NS = 10;
  localparam int POWER_WINDOW_MS = 1;
  localparam int POWER_WINDOW_CYCLES =
    (POWER_WINDOW_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    PM_NORMAL,
    PM_HALT,
    PM_IDLE,
    PM_STOP
  } psm_power_type;

  typedef enum logic [2:0] {
    BS_IDLE,
    BS_T1,
    BS_T2,
    BS_T3,
    BS_TI,
    BS_HOLD
  } psm_bus_state_type;
endpackage
`default_nettype wire

// ===== psm_sync.sv
/*
  two flip-flop synchroniser for a group of asynchronous pin inputs.
  assumes the inputs are levels that stay stable for several clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module psm_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1_r;
  logic [WIDTH-1:0] stage2_r;
  logic [WIDTH-1:0] stage1_nxt;
  logic [WIDTH-1:0] stage2_nxt;

  always_comb begin
    stage1_nxt = reset ? RESET_VAL : asyncIn;
    stage2_nxt = reset ? RESET_VAL : stage1_r;
  end

  always_ff @(posedge clk) begin
    stage1_r <= stage1_nxt;
    stage2_r <= stage2_nxt;
  end

  assign syncOut = stage2_r;
endmodule
`default_nettype wire

// ===== psm_axil_slave.sv
/*
  axi4-lite slave front end: takes write address and data in either
  order, then pulses a register write; reads return the data and error
  flag offered by the register decode of the parent one cycle later.
  assumes one outstanding write and one outstanding read.
*/
`timescale 1ns/1ps
`default_nettype none
module psm_axil_slave
  import psm_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [psm_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [psm_pkg::DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [psm_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [psm_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic regWrite,
  output logic [psm_pkg::ADDR_W-1:0] regWaddr,
  output logic [psm_pkg::DATA_W-1:0] regWdata,
  output logic [3:0] regWstrb,
  input wire logic regWerr,
  output logic [psm_pkg::ADDR_W-1:0] regRaddr,
  input wire logic [psm_pkg::DATA_W-1:0] regRdata,
  input wire logic regRerr
);
  logic awHave_r, awHave_nxt, wHave_r, wHave_nxt;
  logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [ADDR_W-1:0] waddr_r, waddr_nxt;
  logic [DATA_W-1:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic doWrite;

  assign awready = !awHave_r && !bvalid_r;
  assign wready = !wHave_r && !bvalid_r;
  assign arready = !rvalid_r;
  assign doWrite = awHave_r && wHave_r;
  assign regWrite = doWrite;
  assign regWaddr = waddr_r;
  assign regWdata = wdata_r;
  assign regWstrb = wstrb_r;
  assign regRaddr = araddr;

  always_comb begin
    awHave_nxt = awHave_r;
    wHave_nxt = wHave_r;
    waddr_nxt = waddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    if (awvalid && awready) begin
      awHave_nxt = 1'b1;
      waddr_nxt = awaddr;
    end
    if (wvalid && wready) begin
      wHave_nxt = 1'b1;
      wdata_nxt = wdata;
      wstrb_nxt = wstrb;
    end
    if (doWrite) begin
      awHave_nxt = 1'b0;
      wHave_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = regWerr ? RESP_SLVERR : RESP_OKAY;
    end else if (bvalid_r && bready) begin
      bvalid_nxt = 1'b0;
    end
    if (arvalid && arready) begin
      rvalid_nxt = 1'b1;
      rdata_nxt = regRdata;
      rresp_nxt = regRerr ? RESP_SLVERR : RESP_OKAY;
    end else if (rvalid_r && rready) begin
      rvalid_nxt = 1'b0;
    end
    if (reset) begin
      awHave_nxt = 1'b0;
      wHave_nxt = 1'b0;
      bvalid_nxt = 1'b0;
      rvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    awHave_r <= awHave_nxt;
    wHave_r <= wHave_nxt;
    waddr_r <= waddr_nxt;
    wdata_r <= wdata_nxt;
    wstrb_r <= wstrb_nxt;
    bvalid_r <= bvalid_nxt;
    bresp_r <= bresp_nxt;
    rvalid_r <= rvalid_nxt;
    rresp_r <= rresp_nxt;
    rdata_r <= rdata_nxt;
  end

  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign rvalid = rvalid_r;
  assign rresp = rresp_r;
  assign rdata = rdata_r;
endmodule
`default_nettype wire

// ===== psm_pin_state_ctrl.sv
/*
  pin state controller: external bus sequencer and pin state override
  for power-on, reset, halt, idle, stop, bus idle and bus hold.
  assumes pin inputs are asynchronous and core-side inputs share clk;
  tri-state and pull resolution is done by the pad ring.
*/
// Chosen here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module psm_pin_state_ctrl
  import psm_pkg::*;
#(
  parameter int PORT_N = 8,
  parameter int WINDOW_CYCLES = psm_pkg::POWER_WINDOW_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [psm_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [psm_pkg::DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [psm_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [psm_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic busReq,
  input wire logic busWrite,
  input wire logic [1:0] busByteEn,
  input wire logic [psm_pkg::BUS_W-1:0] busAddr,
  input wire logic [psm_pkg::BUS_W-1:0] busWdata,
  output logic [psm_pkg::BUS_W-1:0] busRdata,
  output logic busDone,
  input wire logic dmaActive,
  input wire logic internalReset,
  input wire logic debugDataIn,
  input wire logic debugDataEn,
  input wire logic [PORT_N-1:0] portOutIn,
  input wire logic [PORT_N-1:0] portOeIn,
  input wire logic [PORT_N-1:0] altActive,
  input wire logic [PORT_N-1:0] altOutIn,
  input wire logic [PORT_N-1:0] altOeIn,
  input wire logic externalResetPinN,
  input wire logic supplyInRange,
  input wire logic holdRequestN,
  input wire logic waitPinN,
  input wire logic [psm_pkg::BUS_W-1:0] muxedAddressDataIn,
  output logic [psm_pkg::BUS_W-1:0] muxedAddressDataOut,
  output logic muxedAddressDataOe,
  output logic [psm_pkg::BUS_W-1:0] addressOut,
  output logic addressOe,
  output logic addressStrobeOut,
  output logic writeStrobeLowByteN,
  output logic writeStrobeHighByteN,
  output logic readStrobeN,
  output logic strobeOe,
  output logic holdAcknowledgeN,
  output logic holdAcknowledgeOe,
  output logic systemClockOutput,
  output logic systemClockOutputOe,
  output logic debugResetInputPulldown,
  output logic debugDataOut,
  output logic debugDataOutOe,
  output logic [PORT_N-1:0] portPinOut,
  output logic [PORT_N-1:0] portPinOe
);
  localparam int CNT_W = $clog2(WINDOW_CYCLES + 1);
  localparam logic [CNT_W-1:0] WINDOW_LAST = CNT_W'(WINDOW_CYCLES - 1);

  function automatic logic isDeepStandby(input psm_power_type m);
    return (m == PM_IDLE) || (m == PM_STOP);
  endfunction

  function automatic logic isRegAddr(input logic [ADDR_W-1:0] a);
    return (a == OFS_CTRL) || (a == OFS_STATUS);
  endfunction

  // pin inputs: extResetN, supply, holdN, waitN, then bus data
  logic extResetN, supplyOk, holdReqN, waitN;
  logic [BUS_W-1:0] adInSync;
  psm_sync #(.WIDTH(4), .RESET_VAL(4'hF)) uSyncCtl (
    .clk(clk),
    .reset(reset),
    .asyncIn({externalResetPinN, supplyInRange, holdRequestN, waitPinN}),
    .syncOut({extResetN, supplyOk, holdReqN, waitN})
  );
  psm_sync #(.WIDTH(BUS_W), .RESET_VAL(16'h0000)) uSyncAd (
    .clk(clk),
    .reset(reset),
    .asyncIn(muxedAddressDataIn),
    .syncOut(adInSync)
  );

  // register bus
  logic regWrite, regWerr, regRerr;
  logic [ADDR_W-1:0] regWaddr, regRaddr;
  logic [DATA_W-1:0] regWdata, regRdata;
  logic [3:0] regWstrb;
  psm_axil_slave uSlave (
    .clk(clk), .reset(reset),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .regWrite(regWrite), .regWaddr(regWaddr), .regWdata(regWdata),
    .regWstrb(regWstrb), .regWerr(regWerr), .regRaddr(regRaddr),
    .regRdata(regRdata), .regRerr(regRerr)
  );

  logic busEn_r, busEn_nxt, sepBus_r, sepBus_nxt;
  logic debugModeSel_r, debugModeSel_nxt;
  psm_power_type mode_r, mode_nxt;
  logic [CNT_W-1:0] winCnt_r, winCnt_nxt;
  logic window_r, window_nxt;
  psm_bus_state_type state_r, state_nxt;

  assign regWerr = !isRegAddr(regWaddr);
  assign regRerr = !isRegAddr(regRaddr);

  always_comb begin
    regRdata = '0;
    if (regRaddr == OFS_CTRL) begin
      regRdata[CTRL_BUS_EN] = busEn_r;
      regRdata[CTRL_SEP_BUS] = sepBus_r;
      regRdata[CTRL_DBG_SEL] = debugModeSel_r;
      regRdata[CTRL_MODE_HI:CTRL_MODE_LO] = mode_r;
    end else if (regRaddr == OFS_STATUS) begin
      regRdata[STAT_STATE_HI:STAT_STATE_LO] = state_r;
      regRdata[STAT_HOLD] = (state_r == BS_HOLD);
      regRdata[STAT_WINDOW] = window_r;
      regRdata[STAT_DMA] = dmaActive;
      regRdata[STAT_EXT_RST] = !extResetN;
    end
  end

  // control register; the debug select survives internal resets
  always_comb begin
    busEn_nxt = busEn_r;
    sepBus_nxt = sepBus_r;
    debugModeSel_nxt = debugModeSel_r;
    mode_nxt = mode_r;
    if (regWrite && regWaddr == OFS_CTRL && regWstrb[0]) begin
      busEn_nxt = regWdata[CTRL_BUS_EN];
      sepBus_nxt = regWdata[CTRL_SEP_BUS];
      debugModeSel_nxt = regWdata[CTRL_DBG_SEL];
      mode_nxt = psm_power_type'(regWdata[CTRL_MODE_HI:CTRL_MODE_LO]);
    end
    if (internalReset || !extResetN) begin
      busEn_nxt = CTRL_BUS_EN_RST;
      mode_nxt = PM_NORMAL;
    end
    if (reset || !extResetN) begin
      sepBus_nxt = CTRL_SEP_BUS_RST;
      debugModeSel_nxt = CTRL_DBG_SEL_RST;
    end
    if (reset) begin
      busEn_nxt = CTRL_BUS_EN_RST;
      mode_nxt = PM_NORMAL;
    end
  end

  // power-on window counts only while the supply is in range
  always_comb begin
    winCnt_nxt = winCnt_r;
    window_nxt = window_r;
    if (!supplyOk) begin
      winCnt_nxt = '0;
      window_nxt = 1'b1;
    end else if (window_r) begin
      winCnt_nxt = winCnt_r + CNT_W'(1);
      if (winCnt_r == WINDOW_LAST)
        window_nxt = 1'b0;
    end
    if (reset) begin
      winCnt_nxt = '0;
      window_nxt = 1'b1;
    end
  end

  logic inReset, busUsable, holdUsable, waitActive;
  assign inReset = reset || !extResetN || internalReset || window_r;
  assign busUsable = (mode_r == PM_NORMAL) ||
                     (mode_r == PM_HALT && dmaActive);
  assign holdUsable = busUsable && !holdReqN;
  assign waitActive = !waitN && !isDeepStandby(mode_r);

  // bus sequencer and registered pin drivers
  logic [BUS_W-1:0] adOut_r, adOut_nxt, addr_r, addr_nxt;
  logic [BUS_W-1:0] rdData_r, rdData_nxt;
  logic adOe_r, adOe_nxt, addrOe_r, addrOe_nxt, address_strobe_out_r, address_strobe_out_nxt;
  logic wrLoN_r, wrLoN_nxt, wrHiN_r, wrHiN_nxt, rdN_r, rdN_nxt;
  logic strobeOe_r, strobeOe_nxt, hldAckN_r, hldAckN_nxt;
  logic system_clock_output_r, system_clock_output_nxt, done_r, done_nxt, write_r, write_nxt;
  logic [1:0] be_r, be_nxt;

  always_comb begin
    state_nxt = state_r;
    adOut_nxt = adOut_r;
    adOe_nxt = adOe_r;
    addr_nxt = addr_r;
    addrOe_nxt = addrOe_r;
    address_strobe_out_nxt = address_strobe_out_r;
    wrLoN_nxt = wrLoN_r;
    wrHiN_nxt = wrHiN_r;
    rdN_nxt = rdN_r;
    strobeOe_nxt = busEn_r;
    hldAckN_nxt = 1'b1;
    rdData_nxt = rdData_r;
    done_nxt = 1'b0;
    write_nxt = write_r;
    be_nxt = be_r;
    system_clock_output_nxt = isDeepStandby(mode_r) ? 1'b0 : !system_clock_output_r;
    case (state_r)
      BS_IDLE: begin
        // two-stage pin sync: read data settles one cycle after TI
        if (done_r && !write_r)
          rdData_nxt = adInSync;
        address_strobe_out_nxt = 1'b0;
        wrLoN_nxt = 1'b1;
        wrHiN_nxt = 1'b1;
        rdN_nxt = 1'b1;
        if (holdUsable) begin
          state_nxt = BS_HOLD;
        end else if (busReq && busUsable && busEn_r && !done_r) begin
          state_nxt = BS_T1;
          write_nxt = busWrite;
          be_nxt = busByteEn;
          addr_nxt = busAddr;
          addrOe_nxt = 1'b1;
          adOut_nxt = sepBus_r ? busWdata : busAddr;
          adOe_nxt = !sepBus_r || busWrite;
          address_strobe_out_nxt = 1'b1;
        end else if (mode_r != PM_NORMAL) begin
          // muxed mode in halt keeps the last drive: undefined level
          if (sepBus_r || isDeepStandby(mode_r))
            adOe_nxt = 1'b0;
        end
      end
      BS_T1: begin
        state_nxt = BS_T2;
        address_strobe_out_nxt = 1'b0;
        if (write_r) begin
          adOut_nxt = busWdata;
          adOe_nxt = 1'b1;
          wrLoN_nxt = !be_r[0];
          wrHiN_nxt = !be_r[1];
        end else begin
          adOe_nxt = 1'b0;
          rdN_nxt = 1'b0;
        end
      end
      BS_T2: begin
        if (!waitActive)
          state_nxt = sepBus_r ? BS_TI : BS_T3;
      end
      BS_T3: begin
        state_nxt = BS_TI;
      end
      BS_TI: begin
        // strobes release here; address and data levels are left as they were
        state_nxt = BS_IDLE;
        wrLoN_nxt = 1'b1;
        wrHiN_nxt = 1'b1;
        rdN_nxt = 1'b1;
        done_nxt = 1'b1;
      end
      BS_HOLD: begin
        adOe_nxt = 1'b0;
        addrOe_nxt = 1'b0;
        strobeOe_nxt = 1'b0;
        hldAckN_nxt = 1'b0;
        if (holdReqN || !busUsable)
          state_nxt = BS_IDLE;
      end
      default: state_nxt = BS_IDLE;
    endcase
    if (isDeepStandby(mode_r) && state_r != BS_HOLD) begin
      wrLoN_nxt = 1'b1;
      wrHiN_nxt = 1'b1;
      rdN_nxt = 1'b1;
      address_strobe_out_nxt = 1'b0;
    end
    if (inReset || !busEn_r) begin
      state_nxt = BS_IDLE;
      adOe_nxt = 1'b0;
      addrOe_nxt = 1'b0;
      strobeOe_nxt = 1'b0;
      address_strobe_out_nxt = 1'b0;
      wrLoN_nxt = 1'b1;
      wrHiN_nxt = 1'b1;
      rdN_nxt = 1'b1;
      system_clock_output_nxt = 1'b0;
      done_nxt = 1'b0;
    end
    if (reset) begin
      adOut_nxt = '0;
      addr_nxt = '0;
      rdData_nxt = '0;
      write_nxt = 1'b0;
      be_nxt = '0;
    end
  end

  // port pins: standby holds, but a running alternate function goes on
  logic [PORT_N-1:0] portOut_r, portOut_nxt, portOe_r, portOe_nxt;
  genvar gi;
  generate
    for (gi = 0; gi < PORT_N; gi++) begin : gPort
      always_comb begin
        portOut_nxt[gi] = portOut_r[gi];
        portOe_nxt[gi] = portOe_r[gi];
        if (inReset) begin
          portOe_nxt[gi] = 1'b0;
        end else if (altActive[gi]) begin
          portOut_nxt[gi] = altOutIn[gi];
          portOe_nxt[gi] = altOeIn[gi];
        end else if (mode_r == PM_NORMAL) begin
          portOut_nxt[gi] = portOutIn[gi];
          portOe_nxt[gi] = portOeIn[gi];
        end
        if (reset)
          portOut_nxt[gi] = 1'b0;
      end
    end
  endgenerate

  // debug pins
  logic dbgPd_r, dbgPd_nxt, dbgOut_r, dbgOut_nxt, dbgOe_r, dbgOe_nxt;
  always_comb begin
    dbgPd_nxt = 1'b0;
    if (reset || !extResetN || window_r)
      dbgPd_nxt = 1'b1;
    else if (internalReset)
      dbgPd_nxt = !debugModeSel_r;
    dbgOe_nxt = debugModeSel_r && (debugDataEn || inReset);
    dbgOut_nxt = debugDataIn;
    if (reset) begin
      dbgOe_nxt = 1'b0;
      dbgOut_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    busEn_r <= busEn_nxt;
    sepBus_r <= sepBus_nxt;
    debugModeSel_r <= debugModeSel_nxt;
    mode_r <= mode_nxt;
    winCnt_r <= winCnt_nxt;
    window_r <= window_nxt;
    state_r <= reset ? BS_IDLE : state_nxt;
    adOut_r <= adOut_nxt;
    adOe_r <= adOe_nxt;
    addr_r <= addr_nxt;
    addrOe_r <= addrOe_nxt;
    address_strobe_out_r <= address_strobe_out_nxt;
    wrLoN_r <= wrLoN_nxt;
    wrHiN_r <= wrHiN_nxt;
    rdN_r <= rdN_nxt;
    strobeOe_r <= strobeOe_nxt;
    hldAckN_r <= hldAckN_nxt;
    system_clock_output_r <= system_clock_output_nxt;
    rdData_r <= rdData_nxt;
    done_r <= done_nxt;
    write_r <= write_nxt;
    be_r <= be_nxt;
    portOut_r <= portOut_nxt;
    portOe_r <= portOe_nxt;
    dbgPd_r <= dbgPd_nxt;
    dbgOut_r <= dbgOut_nxt;
    dbgOe_r <= dbgOe_nxt;
  end

  assign muxedAddressDataOut = adOut_r;
  assign muxedAddressDataOe = adOe_r;
  assign addressOut = addr_r;
  assign addressOe = addrOe_r;
  assign addressStrobeOut = address_strobe_out_r;
  assign writeStrobeLowByteN = wrLoN_r;
  assign writeStrobeHighByteN = wrHiN_r;
  assign readStrobeN = rdN_r;
  assign strobeOe = strobeOe_r;
  assign holdAcknowledgeN = hldAckN_r;
  assign holdAcknowledgeOe = strobeOe_r || (state_r == BS_HOLD);
  assign systemClockOutput = system_clock_output_r;
  assign systemClockOutputOe = busEn_r && !inReset;
  assign busRdata = rdData_r;
  assign busDone = done_r;
  assign debugResetInputPulldown = dbgPd_r;
  assign debugDataOut = dbgOut_r;
  assign debugDataOutOe = dbgOe_r;
  assign portPinOut = portOut_r;
  assign portPinOe = portOe_r;
endmodule
`default_nettype wire

// ===== psm_chk.sv
/*
  port assertions for the pin state controller.
  assumes a bind into psm_pin_state_ctrl, one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module psm_chk #(
  parameter int PORT_N = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [psm_pkg::DATA_W-1:0] rdata,
  input wire logic busDone,
  input wire logic addressStrobeOut,
  input wire logic muxedAddressDataOe,
  input wire logic addressOe,
  input wire logic strobeOe,
  input wire logic writeStrobeLowByteN,
  input wire logic readStrobeN,
  input wire logic holdAcknowledgeN,
  input wire logic debugResetInputPulldown,
  input wire logic [PORT_N-1:0] portPinOe
);
  sequence s_cycStart;
    $rose(addressStrobeOut);
  endsequence
  // reset checks carry no disable: they look at the edge after reset
  a_reset_hiz: assert property (@(posedge clk)
    reset |=> !muxedAddressDataOe && !addressOe && !strobeOe)
    else $error("bus pins driven after reset");
  a_reset_strobes: assert property (@(posedge clk)
    reset |=> writeStrobeLowByteN && readStrobeN && holdAcknowledgeN)
    else $error("strobes not high after reset");
  a_port_hiz: assert property (@(posedge clk)
    reset |=> portPinOe == '0)
    else $error("port pins driven in power window");
  a_reset_pull: assert property (@(posedge clk)
    reset |=> debugResetInputPulldown)
    else $error("debug reset pull-down off after reset");
  a_hold_hiz: assert property (@(posedge clk) disable iff (reset)
    !holdAcknowledgeN |-> !muxedAddressDataOe && !strobeOe && !addressOe)
    else $error("bus driven during hold");
  a_strobe_t1: assert property (@(posedge clk) disable iff (reset)
    s_cycStart |=> !addressStrobeOut)
    else $error("address strobe longer than one state");
  a_cycle_done: assert property (@(posedge clk) disable iff (reset)
    s_cycStart |-> ##[3:60] busDone)
    else $error("bus cycle did not finish");
  a_bresp_stands: assert property (@(posedge clk) disable iff (reset)
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  a_rdata_stands: assert property (@(posedge clk) disable iff (reset)
    rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
endmodule
bind psm_pin_state_ctrl psm_chk #(.PORT_N(PORT_N)) u_chk (.*);
`default_nettype wire

// ===== psm_mem_model.sv
/*
  external memory and hold requester on the far side of the bus.
  assumes read and write strobes active low, address strobe active high; released data lines show a moving pattern.
*/
`timescale 1ns/1ps
`default_nettype none
module psm_mem_model (
  input wire logic clk,
  input wire logic [15:0] addrPins,
  input wire logic addrOe,
  input wire logic [15:0] adPins,
  input wire logic adOe,
  input wire logic address_strobe_out,
  input wire logic en,
  input wire logic wrLoN,
  input wire logic wrHiN,
  input wire logic rdN,
  input wire logic holdReq,
  input wire logic slow,
  output logic [15:0] adIn,
  output logic holdRequestN,
  output logic waitPinN
);
  logic [15:0] mem [16];
  logic [3:0] a;
  logic [1:0] hold;
  logic [15:0] lastW;
  logic rd;
  assign rd = en && !rdN;
  // data stays two cycles after the read strobe, then the lines float
  assign adIn = adOe ? adPins : (rd || hold != 0) ? mem[a] : ~lastW;
  assign holdRequestN = !holdReq;
  assign waitPinN = !(slow && rd);
  always @(posedge clk) begin
    lastW <= adIn;
    if (address_strobe_out) a <= addrOe ? addrPins[3:0] : adPins[3:0];
    if (en && !wrLoN) mem[a][7:0] <= adPins[7:0];
    if (en && !wrHiN) mem[a][15:8] <= adPins[15:8];
    hold <= rd ? 2'h2 : (hold != 0 ? hold - 2'h1 : 2'h0);
  end
endmodule
`default_nettype wire

// ===== tb_top.sv
/*
  self-checking bench for the pin state controller.
  assumes the memory model on the bus and a short power window.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import psm_pkg::*;
  typedef struct {logic w; logic [31:0] a, d, e; logic [1:0] r;} psm_row_type;
  logic clk, reset, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, busReq, busWrite, busDone;
  logic [31:0] awaddr, wdata, araddr, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, busByteEn, r;
  logic [15:0] busAddr, busWdata, busRdata, muxedAddressDataIn;
  logic [15:0] muxedAddressDataOut, addressOut;
  logic dmaActive, internalReset, debugDataIn, debugDataEn;
  logic [7:0] portOutIn, portOeIn, altActive, altOutIn, altOeIn;
  logic [7:0] portPinOut, portPinOe;
  logic externalResetPinN, supplyInRange, holdRequestN, waitPinN;
  logic muxedAddressDataOe, addressOe, addressStrobeOut, strobeOe;
  logic writeStrobeLowByteN, writeStrobeHighByteN, readStrobeN;
  logic holdAcknowledgeN, holdAcknowledgeOe, systemClockOutput;
  logic systemClockOutputOe, debugResetInputPulldown, debugDataOut;
  logic debugDataOutOe, holdReq, slow;
  int fails, checksDone, cycles;
  psm_row_type rows [5] = '{'{0, 0, 0, 0, RESP_OKAY},
    '{1, 0, 32'h37, 0, RESP_OKAY}, '{0, 0, 0, 32'h37, RESP_OKAY},
    '{1, 32'h8, 32'h5, 0, RESP_SLVERR}, '{0, 32'h8, 0, 0, RESP_SLVERR}};

  psm_pin_state_ctrl #(.WINDOW_CYCLES(20)) i_dut (.*);
  psm_mem_model i_mem (.clk(clk), .addrPins(addressOut), .addrOe(addressOe),
    .adPins(muxedAddressDataOut), .adOe(muxedAddressDataOe),
    .address_strobe_out(addressStrobeOut), .en(strobeOe), .wrLoN(writeStrobeLowByteN),
    .wrHiN(writeStrobeHighByteN), .rdN(readStrobeN), .holdReq(holdReq),
    .slow(slow), .adIn(muxedAddressDataIn), .holdRequestN(holdRequestN),
    .waitPinN(waitPinN));

  always #5 clk = !clk;

  task chk(input logic [31:0] g, e);
    checksDone++;
    if (g !== e) begin
      fails++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task complete_run();
    if (fails == 0 && checksDone > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // all bus tasks are entered and left just after a rising edge
  task axw(input logic [31:0] a, v, output logic [1:0] rs);
    logic ta, tw;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    ta = 0;
    tw = 0;
    while (!(ta && tw)) begin
      @(negedge clk);
      ta = ta | awready;
      tw = tw | wready;
      @(posedge clk);
      awvalid <= !ta;
      wvalid <= !tw;
    end
    ta = 0;
    while (!ta) begin
      @(negedge clk);
      ta = bvalid;
      rs = bresp;
      @(posedge clk);
    end
    bready <= 1'b0;
    @(posedge clk);
  endtask

  task axr(input logic [31:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic t;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    t = 0;
    while (!t) begin
      @(negedge clk);
      t = arready;
      @(posedge clk);
    end
    arvalid <= 1'b0;
    t = 0;
    while (!t) begin
      @(negedge clk);
      t = rvalid;
      v = rdata;
      rs = rresp;
      @(posedge clk);
    end
    rready <= 1'b0;
    @(posedge clk);
  endtask

  task busOp(input logic w, input logic [15:0] a, v, input logic [1:0] be);
    logic t;
    busReq <= 1'b1;
    busWrite <= w;
    busAddr <= a;
    busWdata <= v;
    busByteEn <= be;
    t = 0;
    while (!t) begin
      @(negedge clk);
      t = busDone;
      @(posedge clk);
    end
    busReq <= 1'b0;
    @(posedge clk);
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      fails++;
      complete_run();
    end
  end

  initial begin
    {clk, awvalid, wvalid, bready, arvalid, rready, busReq, busWrite} = '0;
    {awaddr, wdata, araddr, busAddr, busWdata, busByteEn} = '0;
    {dmaActive, internalReset, supplyInRange, holdReq, slow} = '0;
    {fails, checksDone, cycles} = '0;
    wstrb = 4'hF;
    debugDataIn = 1'b1;
    debugDataEn = 1'b1;
    portOutIn = 8'hC3;
    portOeIn = 8'hFF;
    altActive = 8'h0F;
    altOutIn = 8'hA5;
    altOeIn = 8'hFF;
    externalResetPinN = 1'b1;
    reset = 1'b1;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    supplyInRange <= 1'b1;
    axr(OFS_STATUS, d, r);
    chk(d[STAT_WINDOW], 1);
    chk(portPinOe, 0);
    chk(debugResetInputPulldown, 1);
    foreach (rows[i]) begin
      if (rows[i].w) axw(rows[i].a, rows[i].d, r);
      else axr(rows[i].a, d, r);
      if (!rows[i].w) chk(d, rows[i].e);
      chk(r, rows[i].r);
    end
    repeat (30) @(posedge clk);
    axr(OFS_STATUS, d, r);
    chk(d[STAT_WINDOW], 0);
    axw(OFS_CTRL, 32'h03, r);
    busOp(1, 16'h5, 16'hA5C3, 2'h3);
    busOp(0, 16'h5, 0, 2'h3);
    chk(busRdata, 16'hA5C3);
    axw(OFS_CTRL, 32'h01, r);
    slow <= 1'b1;
    busOp(1, 16'h6, 16'h3C5A, 2'h1);
    busOp(0, 16'h6, 0, 2'h3);
    chk(busRdata & 16'h00FF, 16'h005A);
    slow <= 1'b0;
    holdReq <= 1'b1;
    while (holdAcknowledgeN !== 1'b0) @(negedge clk);
    chk({muxedAddressDataOe, strobeOe, holdAcknowledgeOe}, 3'b001);
    @(posedge clk) holdReq <= 1'b0;
    while (holdAcknowledgeN !== 1'b1) @(posedge clk);
    axw(OFS_CTRL, 32'h13, r);
    dmaActive <= 1'b1;
    busOp(0, 16'h5, 0, 2'h3);
    chk(busRdata, 16'hA5C3);
    busOp(1, 16'h5, 16'hA5C3, 2'h3);
    dmaActive <= 1'b0;
    repeat (3) @(negedge clk);
    chk(muxedAddressDataOe, 0);
    @(posedge clk);
    axw(OFS_CTRL, 32'h23, r);
    repeat (4) @(negedge clk);
    chk(systemClockOutput, 0);
    @(negedge clk);
    chk(systemClockOutput, 0);
    chk({writeStrobeLowByteN, writeStrobeHighByteN, readStrobeN}, 7);
    @(posedge clk);
    axw(OFS_CTRL, 32'h33, r);
    portOutIn <= 8'h3C;
    altOutIn <= 8'h5A;
    repeat (4) @(negedge clk);
    chk(portPinOut, 8'hCA);
    @(posedge clk);
    axw(OFS_CTRL, 32'h04, r);
    internalReset <= 1'b1;
    repeat (3) @(negedge clk);
    chk(debugResetInputPulldown, 0);
    chk(debugDataOutOe, 1);
    @(posedge clk);
    internalReset <= 1'b0;
    axw(OFS_CTRL, 32'h00, r);
    repeat (2) @(negedge clk);
    chk(debugDataOutOe, 0);
    @(posedge clk);
    externalResetPinN <= 1'b0;
    repeat (4) @(negedge clk);
    chk(debugResetInputPulldown, 1);
    chk(muxedAddressDataOe, 0);
    complete_run();
  end
endmodule
`default_nettype wire
